// ---- hdl/psdf_pkg.sv ----
`default_nettype none
package psdf_pkg;
   // ----------------------------------------
   // sizes and codes
   // ----------------------------------------
   localparam int          PSDF_CHANNELS    = 6;     // output channels
   localparam int          PSDF_SEL_W       = 3;     // sense selector width
   localparam logic [2:0]  PSDF_SEL_OFF_A   = 3'h6;  // selector code: sense off
   localparam logic [2:0]  PSDF_SEL_OFF_B   = 3'h7;  // selector code: sense off
   localparam logic [2:0]  PSDF_SEL_RESET   = 3'h7;  // selector after reset: off
   localparam logic [5:0]  PSDF_WARN_RESET  = 6'h00; // warning word after reset
   localparam logic [5:0]  PSDF_LATCH_RESET = 6'h00; // latch-off after reset
   localparam logic        PSDF_BYPASS_RESET = 1'b0; // bypass flag after reset
endpackage
`default_nettype wire

// ---- hdl/psdf_sense_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sense output enable for one selected channel
// ----------------------------------------
module psdf_sense_gate (
   input  wire logic clk,         // system clock
   input  wire logic reset_n,     // synchronous reset, active low
   input  wire logic sel_valid,   // selector names a real channel
   input  wire logic ch_on,       // selected channel switched on
   input  wire logic ch_bypass,   // selected channel vds above threshold
   input  wire logic ch_diag_en,  // diagnosis enabled
   input  wire logic ch_fault,    // any fault on selected channel
   output logic      sense_oe_n   // low while sense output drives
);
   typedef struct packed {
      logic oe_n;                  // registered enable, active low
   } psdf_gate_state_t;

   psdf_gate_state_t st_reg;       // current state
   psdf_gate_state_t st_next;      // next state

   // all conditions must hold, otherwise high impedance
   always_comb begin
      st_next = st_reg;
      st_next.oe_n = ~(sel_valid & ch_on & ~ch_bypass & ch_diag_en & ~ch_fault);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_reg <= '{oe_n: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sense_oe_n = st_reg.oe_n;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // a fault seen on one edge must leave the pin released on the next
   gate_fault_a: assert property (@(posedge clk) disable iff (!reset_n)
      ch_fault |=> sense_oe_n) else $error("sense enabled with fault");
   gate_diag_a: assert property (@(posedge clk) disable iff (!reset_n)
      !ch_diag_en |=> sense_oe_n) else $error("sense enabled with diag off");
   // driving needs a channel that was on and below the bypass threshold
   gate_on_a: assert property (@(posedge clk) disable iff (!reset_n)
      !sense_oe_n |-> $past(ch_on && !ch_bypass)) else $error("sense enabled on off or bypassed channel");
   gate_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      !sel_valid |=> sense_oe_n) else $error("sense enabled without selection");
endmodule
`default_nettype wire

// ---- hdl/psdf_diag_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module psdf_diag_flags #(
   parameter int CHANNELS = psdf_pkg::PSDF_CHANNELS,  // channel count
   parameter int SEL_W    = psdf_pkg::PSDF_SEL_W      // selector width
) (
   input  wire logic                clk,                   // system clock
   input  wire logic                reset_n,               // synchronous reset, active low
   input  wire logic [CHANNELS-1:0] overtemp,              // per-channel overtemperature
   input  wire logic [CHANNELS-1:0] overload,              // per-channel overload monitor
   input  wire logic [CHANNELS-1:0] restart_limit,         // restart count exhausted
   input  wire logic [CHANNELS-1:0] channel_on,            // channel switched on
   input  wire logic [CHANNELS-1:0] vds_above_bypass,      // vds above bypass_threshold
   input  wire logic [CHANNELS-1:0] hard_fault,            // hard failure per channel
   input  wire logic                diag_enable,           // diagnosis enabled
   input  wire logic                sel_write,             // pulse: load selector
   input  wire logic [SEL_W-1:0]    sel_data,              // new selector value
   input  wire logic                warn_word_sent,        // pulse: warning word sent
   input  wire logic                clear_latches_cmd,     // pulse: clear protection latches
   output logic [CHANNELS-1:0]      warning_diag_word,     // latched warning word
   output logic [CHANNELS-1:0]      latched_off,           // protection latches
   output logic [SEL_W-1:0]         sense_channel_select,  // current selector
   output logic                     bypass_monitor_flag,   // standard word bypass bit
   output logic                     sense_out_oe_n,        // low while sense output drives
   output logic [SEL_W-1:0]         sense_route            // channel routed to sense pin
);
   import psdf_pkg::*;
   // limitation: restart counting lives elsewhere; this block only remembers
   // the latch-off levels it is handed and drops them on the clear command

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [CHANNELS-1:0] warn;    // sticky warnings
      logic [CHANNELS-1:0] latch;   // protection latch-off
      logic [SEL_W-1:0]    sel;     // sense selector
      logic                bypass;  // bypass flag
      logic [SEL_W-1:0]    route;   // routed channel copy
   } psdf_state_t;

   // value after reset: nothing warned, nothing latched, sense selector off
   localparam psdf_state_t ST_RESET = '{
      warn:   CHANNELS'(PSDF_WARN_RESET),
      latch:  CHANNELS'(PSDF_LATCH_RESET),
      sel:    SEL_W'(PSDF_SEL_RESET),
      bypass: PSDF_BYPASS_RESET,
      route:  SEL_W'(PSDF_SEL_RESET)
   };

   psdf_state_t st_reg;   // current state
   psdf_state_t st_next;  // next state

   // selector codes at or above channel count, or off codes, disable sense
   function automatic logic sel_ok(input logic [SEL_W-1:0] s);
      sel_ok = (s != PSDF_SEL_OFF_A) && (s != PSDF_SEL_OFF_B) && (int'(s) < CHANNELS);
   endfunction

   // bit of the selected channel, zero when the selector names none;
   // keeps an out-of-range selector from indexing past the vector
   function automatic logic sel_bit(input logic [CHANNELS-1:0] v, input logic [SEL_W-1:0] s);
      sel_bit = 1'b0;
      if (sel_ok(s)) begin
         sel_bit = v[s];
      end
   endfunction

   logic                sel_is_valid;  // selector names a channel
   logic                sel_on;        // selected channel on
   logic                sel_bp;        // selected channel vds above threshold
   logic                sel_fault;     // selected channel faulted
   logic [CHANNELS-1:0] fault_any;     // per-channel fault terms for sense
   logic [CHANNELS-1:0] raw_warn;      // unlatched warning terms

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   // everything follows the registered selector, so a new selection
   // reaches sense and bypass one edge after the write
   always_comb begin
      sel_is_valid = sel_ok(st_reg.sel);
      sel_on       = sel_bit(channel_on, st_reg.sel);
      sel_bp       = sel_bit(vds_above_bypass, st_reg.sel);
      // hard failure or overtemperature blocks sense, overload does not; latch-off counts as fault
      fault_any    = hard_fault | overtemp | st_reg.latch;
      // no channel selected: treat as faulted so sense stays off
      sel_fault    = sel_is_valid ? sel_bit(fault_any, st_reg.sel) : 1'b1;
      raw_warn     = overtemp | overload;
      st_next      = st_reg;
      // one send pulse per frame; the whole word leaves in that frame
      // send clears, but new events and latched-off channels win
      if (warn_word_sent) begin
         st_next.warn = (st_reg.warn & st_reg.latch) | raw_warn;
      end else begin
         st_next.warn = st_reg.warn | raw_warn;
      end
      // a limit still high during the clear leaves the channel latched
      // latches only cleared by command; new limit wins over clear
      if (clear_latches_cmd) begin
         st_next.latch = restart_limit;
      end else begin
         st_next.latch = st_reg.latch | restart_limit;
      end
      // selector changes only through the serial write
      if (sel_write) begin
         st_next.sel = sel_data;
      end
      // the flag is the vds comparison itself: high while off with the
      // output low, low while on or with the output held at supply
      if (sel_is_valid) begin
         st_next.bypass = sel_bp;
      end else begin
         // nothing selected: report as if the output were low
         st_next.bypass = 1'b1;
      end
      st_next.route  = st_reg.sel;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // whole state in one register; reset loads the constant above
   // so no field can be forgotten when the struct grows
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // sense gate, one cycle behind the selected inputs
   psdf_sense_gate u_gate (
      .clk        (clk),
      .reset_n    (reset_n),
      .sel_valid  (sel_is_valid),
      .ch_on      (sel_on),
      .ch_bypass  (sel_bp),
      .ch_diag_en (diag_enable),
      .ch_fault   (sel_fault),
      .sense_oe_n (sense_out_oe_n)
   );

   // outputs come straight from the state register
   assign warning_diag_word    = st_reg.warn;
   assign latched_off          = st_reg.latch;
   assign sense_channel_select = st_reg.sel;
   assign bypass_monitor_flag  = st_reg.bypass;
   assign sense_route          = st_reg.route;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // warning terms of channel 0 reach the word one edge later
   warn_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      (overtemp[0] | overload[0]) |=> warning_diag_word[0]) else $error("warning not set");
   // a send with nothing new and no latch-off clears the bit
   warn_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (warn_word_sent && !latched_off[0] && !overtemp[0] && !overload[0]) |=> !warning_diag_word[0])
      else $error("warning not cleared");
   // a latched-off channel keeps its warning through a send
   warn_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (latched_off[0] && warning_diag_word[0]) |=> warning_diag_word[0]) else $error("latched warning lost");

   // latches move only on the clear command or a new limit
   latch_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
      (latched_off[0] && !clear_latches_cmd) |=> latched_off[0]) else $error("latch dropped");
   latch_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (clear_latches_cmd && !restart_limit[0]) |=> !latched_off[0]) else $error("latch not cleared");
   latch_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      restart_limit[0] |=> latched_off[0]) else $error("latch not set");

   // the selector only takes what the serial write carries
   sel_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      sel_write |=> sense_channel_select == $past(sel_data)) else $error("selector not loaded");
   sel_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
      !sel_write |=> $stable(sense_channel_select)) else $error("selector moved");

   // both off codes release the sense pin; route trails the selector
   sel_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      (sense_channel_select == PSDF_SEL_OFF_A) |=> sense_out_oe_n) else $error("sense on for off code");
   sel_off_b_a: assert property (@(posedge clk) disable iff (!reset_n)
      (sense_channel_select == PSDF_SEL_OFF_B) |=> sense_out_oe_n) else $error("sense on for off code");
   route_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
      1'b1 |=> sense_route == $past(sense_channel_select)) else $error("route not following selector");

   // bypass flag mirrors the selected comparison, set with no selection;
   // the reset edge is skipped because the flag resets low
   bypass_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      (sense_channel_select == 3'h1) |=> bypass_monitor_flag == $past(vds_above_bypass[1]))
      else $error("bypass flag wrong");
   bypass_none_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!sel_ok(sense_channel_select) && $past(reset_n)) |=> bypass_monitor_flag)
      else $error("bypass flag wrong without selection");

   // sense released while diagnosis is off or a hard failure is present
   diag_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !diag_enable |=> sense_out_oe_n) else $error("sense on with diag off");
   hard_fault_a: assert property (@(posedge clk) disable iff (!reset_n)
      (sense_channel_select == 3'h1 && hard_fault[1]) |=> sense_out_oe_n)
      else $error("sense on with hard failure");

   // main scenarios worth seeing at least once
   sense_on_c: cover property (@(posedge clk) disable iff (!reset_n) !sense_out_oe_n);
   warn_kept_c: cover property (@(posedge clk) disable iff (!reset_n)
      warn_word_sent && latched_off[0] && warning_diag_word[0]);
   clear_c: cover property (@(posedge clk) disable iff (!reset_n) clear_latches_cmd && latched_off != '0);
   bypass_seen_c: cover property (@(posedge clk) disable iff (!reset_n)
      bypass_monitor_flag && sense_channel_select == 3'h1);
endmodule
`default_nettype wire

// ---- testbench/psdf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial host: selector, send, clear pulses
// ----------------------------------------
module psdf_host_model (
   input  wire logic  clk,        // system clock
   output logic       sel_write,  // selector load pulse
   output logic [2:0] sel_data,   // selector value
   output logic       warn_sent,  // warning word sent
   output logic       clear_cmd   // clear latches pulse
);
   // idle levels from time zero
   initial begin
      sel_write = 1'b0;
      sel_data  = 3'h7;
      warn_sent = 1'b0;
      clear_cmd = 1'b0;
   end
   // pulses last one cycle; data held after
   task automatic write_sel(input logic [2:0] v);
      @(posedge clk) begin sel_write <= 1'b1; sel_data <= v; end
      @(posedge clk) sel_write <= 1'b0;
   endtask
   task automatic send_warn;
      @(posedge clk) warn_sent <= 1'b1;
      @(posedge clk) warn_sent <= 1'b0;
   endtask
   task automatic clear_latch;
      @(posedge clk) clear_cmd <= 1'b1;
      @(posedge clk) clear_cmd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- testbench/psdf_diag_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module psdf_diag_flags_tb;
   import psdf_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       clk = 1'b0;      // system clock
   logic       reset_n = 1'b0;  // active-low reset
   logic [5:0] ot = 6'h00, ol = 6'h00, rl = 6'h00; // faults
   logic [5:0] chon = 6'h00, vds = 6'h00, hf = 6'h00; // state
   logic       den = 1'b0;      // diagnosis enable
   logic       sw, ws, clc;     // host pulses
   logic [2:0] sd, sel, rte;    // selector paths
   logic [5:0] wrn, lat;        // flag words
   logic       byp, oen;        // bypass, sense enable
   int         fails = 0;       // mismatches
   int         comparisons = 0; // checks made
   int         cyc = 0;         // timeout count
   initial forever #5 clk = ~clk;
   psdf_host_model HOST (.clk(clk), .sel_write(sw), .sel_data(sd),
      .warn_sent(ws), .clear_cmd(clc));
   psdf_diag_flags DUT (.clk(clk), .reset_n(reset_n), .overtemp(ot),
      .overload(ol), .restart_limit(rl), .channel_on(chon),
      .vds_above_bypass(vds), .hard_fault(hf), .diag_enable(den),
      .sel_write(sw), .sel_data(sd), .warn_word_sent(ws),
      .clear_latches_cmd(clc), .warning_diag_word(wrn), .latched_off(lat),
      .sense_channel_select(sel), .bypass_monitor_flag(byp),
      .sense_out_oe_n(oen), .sense_route(rte));
   task automatic chk(input string n, input logic [5:0] e, input logic [5:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // settle past the edge before looking
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far above the sequence length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fails++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      tick(1);
      chk("warn rst", PSDF_WARN_RESET, wrn);
      chk("latch rst", PSDF_LATCH_RESET, lat);
      chk("sel rst", 6'(PSDF_SEL_RESET), 6'(sel));
      chk("oe rst", 6'h01, 6'(oen));
      $display("test reset done");
      @(posedge clk) begin ol <= 6'h01; ot <= 6'h08; end
      @(posedge clk) begin ol <= 6'h00; ot <= 6'h00; end
      #1 chk("warn set", 6'h09, wrn);
      HOST.send_warn();
      #1 chk("warn clr", 6'h00, wrn);
      // latched-off channels keep their warning
      @(posedge clk) begin rl <= 6'h05; ol <= 6'h05; end
      @(posedge clk) begin rl <= 6'h00; ol <= 6'h00; end
      HOST.send_warn();
      #1 chk("warn kept", 6'h05, wrn);
      chk("latch held", 6'h05, lat);
      HOST.clear_latch();
      #1 chk("latch clr", 6'h00, lat);
      HOST.send_warn();
      #1 chk("warn freed", 6'h00, wrn);
      $display("test warnings done");
      @(posedge clk) begin den <= 1'b1; chon <= 6'h02; end
      HOST.write_sel(3'h1);
      tick(2);
      chk("sel", 6'h01, 6'(sel));
      chk("route", 6'h01, 6'(rte));
      chk("sense on", 6'h00, 6'(oen));
      chk("byp low vds", 6'h00, 6'(byp));
      // one spoiler at a time: bypass, disable, hard fault, overtemp
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) begin
            vds <= (i == 0) ? 6'h02 : 6'h00;
            den <= (i != 1);
            hf  <= (i == 2) ? 6'h02 : 6'h00;
            ot  <= (i == 3) ? 6'h02 : 6'h00;
         end
         tick(2);
         chk("sense off", 6'h01, 6'(oen));
         if (i == 0) chk("byp hi vds", 6'h01, 6'(byp));
      end
      @(posedge clk) ot <= 6'h00;
      tick(2);
      chk("sense back", 6'h00, 6'(oen));
      for (int c = 6; c < 8; c++) begin
         HOST.write_sel(3'(c));
         tick(2);
         chk("off code", 6'h01, 6'(oen));
         chk("route off", 6'(c), 6'(rte));
         chk("byp no sel", 6'h01, 6'(byp));
      end
      $display("test sense done");
      finish_test();
   end
endmodule
`default_nettype wire
